// ### logic/line_monitor_pkg.sv
package line_monitor_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_RESULT = 8'h0a;
    localparam logic [7:0] IDX_CONFIG_TWO = 8'h0c;
    localparam logic [7:0] IDX_TIMEOUT = 8'h11;
    localparam logic [7:0] IDX_DIP_CYCLES = 8'h13;
    localparam logic [7:0] IDX_DIP_THRESHOLD = 8'h14;
    localparam logic [7:0] IDX_METER_ENABLE = 8'hdb;
    localparam logic [7:0] IDX_METER_STATUS = 8'hde;
    localparam logic [7:0] IDX_METER_CLEAR = 8'hdf;
    localparam logic [7:0] IDX_SUPPLY_ENABLE = 8'hec;
    localparam logic [7:0] IDX_SUPPLY_FLAGS = 8'hf8;
    localparam logic [7:0] IDX_SUPPLY_CLEAR = 8'hf9;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_ZERO_CROSS = 0;
    localparam int BIT_TIMEOUT = 1;
    localparam int BIT_DIP = 5;
    localparam int BIT_LINE_LOWPASS = 0;
    localparam int BIT_FREQ_SELECT = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [11:0] TIMEOUT_RESET = 12'hfff;
    localparam logic [7:0] DIP_CYCLES_RESET = 8'hff;
    localparam logic [15:0] DIP_THRESHOLD_RESET = 16'h0000;
    localparam logic [1:0] CONFIG_TWO_RESET = 2'h1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int TIMEOUT_TICK_CLKS = 160;
    localparam int PERIOD_TICK_CLKS = 10;
    localparam int FREQ_STEPS_PER_HZ = 16;
    localparam logic [23:0] FREQ_NUMERATOR =
        24'(CLK_HZ / PERIOD_TICK_CLKS * FREQ_STEPS_PER_HZ);
    localparam logic [7:0] TIMEOUT_TICK_LAST = 8'(TIMEOUT_TICK_CLKS - 1);
    localparam logic [3:0] PERIOD_TICK_LAST = 4'(PERIOD_TICK_CLKS - 1);
    localparam logic [4:0] DIV_STEPS = 5'h18;

endpackage

// ### logic/line_voltage_quality_monitor.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Crossing source: filtered sample, else raw sample.
// - Crossing sets flag; enabled flag holds interrupt.
// - Timeout counter: 12 bits, minus one per 160.
// - Every crossing reloads timeout counter from register.
// - Timeout register resets to all ones.
// - Counter reaching zero sets timeout flag; enabled flag holds interrupt.
// - Timeout register is read and write.
// - Config bit one chooses period or frequency.
// - Sixteen-bit result updates once per line period.
// - Period counted in units of ten clocks.
// - Frequency reported in sixteenths of one hertz.
// - Dip while filtered magnitude below threshold.
// - Dip flag set after programmed count minus one.
// - Enabled dip flag holds supply interrupt.
// - Threshold compares against filtered magnitude upper bits.
module line_voltage_quality_monitor
    import line_monitor_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [9:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic sample_valid_in,
    input wire logic [23:0] raw_sample_in,
    input wire logic [23:0] filtered_sample_in,
    output logic zero_cross_out,
    output logic meter_irq_out,
    output logic supply_irq_out
);

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    // Misaligned byte addresses decode to an index that matches nothing.
    function automatic logic [8:0] reg_index(input logic [9:0] addr);
        reg_index = (addr[1:0] == 2'h0) ? {1'b0, addr[9:2]} : 9'h100;
    endfunction

    logic [8:0] idx;
    logic wr_config, wr_timeout, wr_cycles, wr_threshold;
    logic wr_meter_en, wr_meter_clr, wr_supply_en, wr_supply_clr;
    assign idx = reg_index(addr_in);
    assign wr_config = wr_in && idx == {1'b0, IDX_CONFIG_TWO};
    assign wr_timeout = wr_in && idx == {1'b0, IDX_TIMEOUT};
    assign wr_cycles = wr_in && idx == {1'b0, IDX_DIP_CYCLES};
    assign wr_threshold = wr_in && idx == {1'b0, IDX_DIP_THRESHOLD};
    assign wr_meter_en = wr_in && idx == {1'b0, IDX_METER_ENABLE};
    assign wr_meter_clr = wr_in && idx == {1'b0, IDX_METER_CLEAR};
    assign wr_supply_en = wr_in && idx == {1'b0, IDX_SUPPLY_ENABLE};
    assign wr_supply_clr = wr_in && idx == {1'b0, IDX_SUPPLY_CLEAR};

    logic [1:0] config_q;
    logic [11:0] timeout_reload_q;
    logic [7:0] dip_cycles_q;
    logic [15:0] dip_threshold_q;
    logic [1:0] meter_en_q;
    logic supply_en_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            config_q <= CONFIG_TWO_RESET;
            timeout_reload_q <= TIMEOUT_RESET;
            dip_cycles_q <= DIP_CYCLES_RESET;
            dip_threshold_q <= DIP_THRESHOLD_RESET;
            meter_en_q <= 2'h0;
            supply_en_q <= 1'b0;
        end
        else
        begin
            if (wr_config)
                config_q <= wdata_in[1:0];
            if (wr_timeout)
                timeout_reload_q <= wdata_in[11:0];
            if (wr_cycles)
                dip_cycles_q <= wdata_in[7:0];
            if (wr_threshold)
                dip_threshold_q <= wdata_in;
            if (wr_meter_en)
                meter_en_q <= wdata_in[1:0];
            if (wr_supply_en)
                supply_en_q <= wdata_in[BIT_DIP];
        end
    end

    logic [15:0] result_q;
    logic [1:0] meter_stat_q;
    logic dip_flag_q;
    logic [15:0] rdata_d;

    always_comb
    begin
        rdata_d = 16'h0000;
        unique case (idx)
            {1'b0, IDX_RESULT}: rdata_d = result_q;
            {1'b0, IDX_CONFIG_TWO}: rdata_d = {14'h0000, config_q};
            {1'b0, IDX_TIMEOUT}: rdata_d = {4'h0, timeout_reload_q};
            {1'b0, IDX_DIP_CYCLES}: rdata_d = {8'h00, dip_cycles_q};
            {1'b0, IDX_DIP_THRESHOLD}: rdata_d = dip_threshold_q;
            {1'b0, IDX_METER_ENABLE}: rdata_d = {14'h0000, meter_en_q};
            {1'b0, IDX_METER_STATUS}: rdata_d = {14'h0000, meter_stat_q};
            {1'b0, IDX_SUPPLY_ENABLE}: rdata_d = 16'(supply_en_q) << BIT_DIP;
            {1'b0, IDX_SUPPLY_FLAGS}: rdata_d = 16'(dip_flag_q) << BIT_DIP;
            default: rdata_d = 16'h0000;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= 16'h0000;
        else
            rdata_out <= rd_in ? rdata_d : 16'h0000;
    end

    // ----------------------------------------------------------------
    // Zero-crossing detection
    // ----------------------------------------------------------------
    // Only negative-to-positive crossings count, so one crossing marks one
    // whole line period for the period and dip logic.
    logic [23:0] zx_source;
    logic prev_negative_q;
    logic zx_event;
    assign zx_source = config_q[BIT_LINE_LOWPASS] ? filtered_sample_in : raw_sample_in;
    assign zx_event = sample_valid_in && prev_negative_q && !zx_source[23];

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prev_negative_q <= 1'b0;
            zero_cross_out <= 1'b0;
        end
        else
        begin
            if (sample_valid_in)
                prev_negative_q <= zx_source[23];
            zero_cross_out <= zx_event;
        end
    end

    // ----------------------------------------------------------------
    // Crossing timeout
    // ----------------------------------------------------------------
    logic [7:0] to_prescale_q;
    logic [11:0] to_count_q;
    logic to_tick, to_event;
    assign to_tick = to_prescale_q == TIMEOUT_TICK_LAST;
    assign to_event = !zx_event && to_tick && to_count_q == 12'h001;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            to_prescale_q <= 8'h00;
            to_count_q <= TIMEOUT_RESET;
        end
        else
        begin
            to_prescale_q <= (to_tick || zx_event) ? 8'h00 : to_prescale_q + 8'h01;
            if (zx_event)
                to_count_q <= timeout_reload_q;
            else if (to_tick && to_count_q != 12'h000)
                to_count_q <= to_count_q - 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // Period and frequency measurement
    // ----------------------------------------------------------------
    // The period count saturates, so a lost line reads full scale rather
    // than wrapping to a plausible small value.
    logic [3:0] per_prescale_q;
    logic [15:0] per_count_q;
    logic per_tick;
    assign per_tick = per_prescale_q == PERIOD_TICK_LAST;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            per_prescale_q <= 4'h0;
            per_count_q <= 16'h0000;
        end
        else if (zx_event)
        begin
            per_prescale_q <= 4'h0;
            per_count_q <= 16'h0000;
        end
        else
        begin
            per_prescale_q <= per_tick ? 4'h0 : per_prescale_q + 4'h1;
            if (per_tick && per_count_q != 16'hffff)
                per_count_q <= per_count_q + 16'h0001;
        end
    end

    // Restoring division of the fixed numerator by the period count.
    // It needs 25 cycles, far less than any real line period.
    logic div_busy_q;
    logic [4:0] div_step_q;
    logic [23:0] div_num_q;
    logic [23:0] div_quo_q;
    logic [16:0] div_rem_q;
    logic [15:0] div_den_q;
    logic [16:0] div_trial;
    logic div_fits, div_done;
    assign div_trial = {div_rem_q[15:0], div_num_q[23]};
    assign div_fits = div_trial >= {1'b0, div_den_q};
    assign div_done = div_busy_q && div_step_q == DIV_STEPS;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            div_busy_q <= 1'b0;
            div_step_q <= 5'h00;
            div_num_q <= 24'h000000;
            div_quo_q <= 24'h000000;
            div_rem_q <= 17'h00000;
            div_den_q <= 16'h0000;
        end
        else if (zx_event && config_q[BIT_FREQ_SELECT])
        begin
            div_busy_q <= 1'b1;
            div_step_q <= 5'h00;
            div_num_q <= FREQ_NUMERATOR;
            div_quo_q <= 24'h000000;
            div_rem_q <= 17'h00000;
            div_den_q <= per_count_q;
        end
        else if (div_done)
            div_busy_q <= 1'b0;
        else if (div_busy_q)
        begin
            div_step_q <= div_step_q + 5'h01;
            div_num_q <= {div_num_q[22:0], 1'b0};
            div_quo_q <= {div_quo_q[22:0], div_fits};
            div_rem_q <= div_fits ? div_trial - {1'b0, div_den_q} : div_trial;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            result_q <= 16'h0000;
        else if (zx_event && !config_q[BIT_FREQ_SELECT])
            result_q <= per_count_q;
        else if (div_done)
            result_q <= (div_den_q == 16'h0000 || div_quo_q[23:16] != 8'h00)
                ? 16'hffff : div_quo_q[15:0];
    end

    // ----------------------------------------------------------------
    // Voltage dip detection
    // ----------------------------------------------------------------
    logic [23:0] filt_abs;
    logic above_level;
    logic [7:0] dip_count_q;
    logic dip_event;
    assign filt_abs = filtered_sample_in[23] ? 24'h000000 - filtered_sample_in : filtered_sample_in;
    assign above_level = sample_valid_in && filt_abs[23:8] >= dip_threshold_q;
    assign dip_event = zx_event && !above_level && dip_count_q != 8'hff
        && dip_count_q + 8'h01 == dip_cycles_q - 8'h01;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            dip_count_q <= 8'h00;
        else if (above_level)
            dip_count_q <= 8'h00;
        else if (zx_event && dip_count_q != 8'hff)
            dip_count_q <= dip_count_q + 8'h01;
    end

    // ----------------------------------------------------------------
    // Interrupt flags
    // ----------------------------------------------------------------
    // A new event in the cycle of a clear keeps its flag set.
    logic [1:0] meter_set;
    assign meter_set = {to_event, zx_event};

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meter_stat_q <= 2'h0;
            dip_flag_q <= 1'b0;
        end
        else
        begin
            meter_stat_q <= (meter_stat_q & ~(wr_meter_clr ? wdata_in[1:0] : 2'h0)) | meter_set;
            dip_flag_q <= (dip_flag_q && !(wr_supply_clr && wdata_in[BIT_DIP])) || dip_event;
        end
    end

    assign meter_irq_out = |(meter_stat_q & meter_en_q);
    assign supply_irq_out = dip_flag_q && supply_en_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_zx_source: assert property (sample_valid_in && prev_negative_q && !zx_source[23]
        |=> zero_cross_out) else $error("crossing not reported");
    chk_zx_flag: assert property (zx_event |=> meter_stat_q[BIT_ZERO_CROSS])
        else $error("crossing flag not set");
    chk_tick_spacing: assert property (to_tick && !zx_event |=> !to_tick [*8])
        else $error("timeout tick too close");
    chk_reload: assert property (zx_event |=> to_count_q == $past(timeout_reload_q))
        else $error("timeout not reloaded");
    chk_timeout_flag: assert property (to_event |=> meter_stat_q[BIT_TIMEOUT] && to_count_q == 12'h000)
        else $error("timeout flag missing");
    chk_reg_readback: assert property (wr_timeout ##1 rd_in && idx == {1'b0, IDX_TIMEOUT} && !wr_in
        |=> rdata_out[11:0] == $past(timeout_reload_q)) else $error("timeout readback wrong");
    chk_period_update: assert property (zx_event && !config_q[BIT_FREQ_SELECT]
        |=> result_q == $past(per_count_q)) else $error("period not captured");
    chk_freq_update: assert property (zx_event && config_q[BIT_FREQ_SELECT]
        |-> ##[25:26] div_done) else $error("frequency not produced");
    chk_dip_restart: assert property (above_level |=> dip_count_q == 8'h00)
        else $error("dip count not restarted");
    chk_dip_flag: assert property (dip_event |=> dip_flag_q && (supply_irq_out == supply_en_q))
        else $error("dip flag or interrupt wrong");
    chk_meter_irq: assert property (meter_stat_q[BIT_ZERO_CROSS] && meter_en_q[BIT_ZERO_CROSS]
        |-> meter_irq_out) else $error("meter interrupt missing");

    cov_crossing: cover property (zx_event ##1 zero_cross_out);
    cov_timeout: cover property (to_event);
    cov_dip: cover property (dip_event);
    cov_freq: cover property (div_done);

endmodule

// ### testbench/line_sample_source.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Voltage channel sample source
// ----------------------------------------------------------------
// A square-wave line keeps every crossing on an exact sample, so periods are known to the clock.
// Between samples the data lines toggle, so nothing may rely on a stale sample.
module line_sample_source
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic hold_filtered_in,
    input wire logic [23:0] amplitude_in,
    output logic sample_valid_out,
    output logic [23:0] raw_sample_out,
    output logic [23:0] filtered_sample_out
);
    localparam int SPACING = 10;
    localparam int HALF = 130;
    logic [3:0] tick_q;
    logic [8:0] phase_q;
    logic [23:0] level;
    assign level = (phase_q < 9'(HALF)) ? amplitude_in : -amplitude_in;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tick_q <= 4'h0;
            phase_q <= 9'h000;
            sample_valid_out <= 1'b0;
            raw_sample_out <= 24'h000000;
            filtered_sample_out <= 24'h000000;
        end
        else if (tick_q == 4'(SPACING - 1))
        begin
            tick_q <= 4'h0;
            phase_q <= (phase_q == 9'(2 * HALF - 1)) ? 9'h000 : phase_q + 9'h001;
            sample_valid_out <= 1'b1;
            raw_sample_out <= level;
            filtered_sample_out <= hold_filtered_in ? amplitude_in : level;
        end
        else
        begin
            tick_q <= tick_q + 4'h1;
            sample_valid_out <= 1'b0;
            raw_sample_out <= ~raw_sample_out;
            filtered_sample_out <= ~filtered_sample_out;
        end
    end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import line_monitor_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic hold_filt = 1'b1;
    logic [9:0] addr = 10'h000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rv;
    logic [23:0] amp = 24'h100000;
    logic sample_valid;
    logic [23:0] raw;
    logic [23:0] filt;
    logic zx;
    logic [15:0] rv_dut;
    logic meter_irq;
    logic supply_irq;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int zx_count = 0;

    always #50 clk_sys = ~clk_sys;

    line_sample_source src (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .hold_filtered_in(hold_filt),
        .amplitude_in(amp), .sample_valid_out(sample_valid), .raw_sample_out(raw), .filtered_sample_out(filt));

    line_voltage_quality_monitor uut (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rv_dut), .sample_valid_in(sample_valid), .raw_sample_in(raw),
        .filtered_sample_in(filt), .zero_cross_out(zx), .meter_irq_out(meter_irq), .supply_irq_out(supply_irq));

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    function automatic logic [9:0] ba(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [9:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        rv = rv_dut;
    endtask

    // Write, then read the same register in the very next cycle with no idle gap.
    task automatic wr_rd_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        rv = rv_dut;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        num_checks++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h outside %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic wait_zx(input int n);
        repeat (n)
        begin
            do
            begin
                @(posedge clk_sys);
                #1;
            end while (zx !== 1'b1);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // The run needs about 65000 cycles; the ceiling leaves headroom for a slow design.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (zx === 1'b1)
            zx_count++;
        if (cycles == 100000)
        begin
            mismatches++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_reg(ba(IDX_TIMEOUT));
        chk(rv, 16'h0fff);
        rd_reg(ba(IDX_CONFIG_TWO));
        chk(rv, 16'h0001);
        rd_reg(ba(IDX_DIP_CYCLES));
        chk(rv, 16'h00ff);
        rd_reg(ba(IDX_DIP_THRESHOLD));
        chk(rv, 16'h0000);
        rd_reg(10'h3fc);
        chk(rv, 16'h0000);
        rd_reg(ba(IDX_TIMEOUT) + 10'h001);
        chk(rv, 16'h0000);
        wr_reg(ba(IDX_RESULT), 16'h1234);
        rd_reg(ba(IDX_RESULT));
        chk(rv, 16'h0000);
        wr_rd_reg(ba(IDX_TIMEOUT), 16'hffff);
        chk(rv, 16'h0fff);
        wr_rd_reg(ba(IDX_TIMEOUT), 16'h0123);
        chk(rv, 16'h0123);
        wr_reg(ba(IDX_TIMEOUT), 16'h0fff);
        // The filtered input sits still while the raw one swings.
        repeat (6000) @(posedge clk_sys);
        chk(16'(zx_count), 16'h0000);
        wr_reg(ba(IDX_CONFIG_TWO), 16'h0000);
        wait_zx(1);
        rd_reg(ba(IDX_METER_STATUS));
        chk(rv & 16'h0001, 16'h0001);
        chk(16'(meter_irq), 16'h0000);
        @(posedge clk_sys);
        hold_filt <= 1'b0;
        wr_reg(ba(IDX_CONFIG_TWO), 16'h0001);
        wr_reg(ba(IDX_METER_ENABLE), 16'h0001);
        #1;
        chk(16'(meter_irq), 16'h0001);
        wr_reg(ba(IDX_METER_CLEAR), 16'h0001);
        rd_reg(ba(IDX_METER_STATUS));
        chk(rv & 16'h0001, 16'h0000);
        chk(16'(meter_irq), 16'h0000);
        wait_zx(2);
        rd_reg(ba(IDX_RESULT));
        chk_rng(rv, 16'd259, 16'd261);
        wr_reg(ba(IDX_CONFIG_TWO), 16'h0003);
        wait_zx(2);
        repeat (30) @(posedge clk_sys);
        rd_reg(ba(IDX_RESULT));
        chk_rng(rv, 16'd61300, 16'd61800);
        wr_reg(ba(IDX_CONFIG_TWO), 16'h0001);
        // Crossings come every 2600 clocks: 17 ticks outlast them, 16 do not.
        wr_reg(ba(IDX_METER_ENABLE), 16'h0002);
        wr_reg(ba(IDX_TIMEOUT), 16'h0011);
        wait_zx(2);
        wr_reg(ba(IDX_METER_CLEAR), 16'h0003);
        wait_zx(2);
        rd_reg(ba(IDX_METER_STATUS));
        chk(rv & 16'h0002, 16'h0000);
        chk(16'(meter_irq), 16'h0000);
        wr_reg(ba(IDX_TIMEOUT), 16'h0010);
        wait_zx(2);
        wr_reg(ba(IDX_METER_CLEAR), 16'h0003);
        wait_zx(1);
        rd_reg(ba(IDX_METER_STATUS));
        chk(rv & 16'h0002, 16'h0002);
        chk(16'(meter_irq), 16'h0001);
        wr_reg(ba(IDX_METER_ENABLE), 16'h0000);
        wr_reg(ba(IDX_DIP_THRESHOLD), 16'h0800);
        wr_reg(ba(IDX_DIP_CYCLES), 16'h0004);
        wait_zx(4);
        rd_reg(ba(IDX_SUPPLY_FLAGS));
        chk(rv, 16'h0000);
        wait_zx(1);
        @(posedge clk_sys);
        amp <= 24'h010000;
        wait_zx(2);
        @(posedge clk_sys);
        amp <= 24'h100000;
        repeat (50) @(posedge clk_sys);
        amp <= 24'h010000;
        wait_zx(2);
        rd_reg(ba(IDX_SUPPLY_FLAGS));
        chk(rv, 16'h0000);
        wait_zx(1);
        rd_reg(ba(IDX_SUPPLY_FLAGS));
        chk(rv, 16'h0020);
        chk(16'(supply_irq), 16'h0000);
        wr_reg(ba(IDX_SUPPLY_ENABLE), 16'h0020);
        #1;
        chk(16'(supply_irq), 16'h0001);
        @(posedge clk_sys);
        amp <= 24'h100000;
        wait_zx(1);
        wr_reg(ba(IDX_SUPPLY_CLEAR), 16'h0020);
        rd_reg(ba(IDX_SUPPLY_FLAGS));
        chk(rv, 16'h0000);
        chk(16'(supply_irq), 16'h0000);
        finish_test();
    end
endmodule
